// File: verilog/uart_irq_defines.svh
`ifndef UART_IRQ_DEFINES_SVH
`define UART_IRQ_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_DATA 8'h00
`define OFS_IEN 8'h04
`define OFS_IID 8'h08
`define OFS_LFR 8'h0c
`define OFS_LSR 8'h14
`define OFS_DHB 8'h24
// ----------------------------------------
// field positions
// ----------------------------------------
`define IEN_LS 2
`define IEN_TX 1
`define IEN_RX 0
`define LFR_LATCH 7
`define QC_EN 0
`define QC_RXFL 1
`define QC_TXFL 2
`define QC_DMA 3
// ----------------------------------------
// codes, reset values, sizes, timing
// ----------------------------------------
`define MODE_FIFO 2'h3
`define MODE_PLAIN 2'h0
`define ID_TX 3'h1
`define ID_RX 3'h2
`define ID_LS 3'h3
`define ID_TO 3'h6
`define ID_NONE 3'h0
`define RST_IEN 3'h0
`define RST_BYTE 8'h00
`define RST_TRIG 2'h0
`define Q_DEPTH 5'h10
`define Q_ONE 5'h01
`define TRIG_L0 5'h01
`define TRIG_L1 5'h04
`define TRIG_L2 5'h08
`define TRIG_L3 5'h0e
`define BCLK_PER_BIT 10'h010
`define STOP_ONE 10'h010
`define STOP_HALF 10'h018
`define STOP_TWO 10'h020
`define CHAR_TIMES_SHIFT 2
`endif

// File: verilog/uart_irq_pkg.sv
`default_nettype none
package uart_irq_pkg;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
    logic brk;
  } rx_char_t;
  typedef struct packed {
    logic [2:0] ien;
    logic [7:0] divisor_high_byte;
    logic [7:0] line_format_register;
    logic queue_mode_on;
    logic [1:0] rx_trigger_level;
    logic dma_handshake_select;
    logic [15:0][10:0] rx_mem;
    logic [3:0] rx_wp;
    logic [3:0] rx_rp;
    logic [4:0] rx_cnt;
    logic [4:0] rx_errs;
    logic [15:0][7:0] tx_mem;
    logic [3:0] tx_wp;
    logic [3:0] tx_rp;
    logic [4:0] tx_cnt;
    logic overrun;
    logic timeout;
    logic [11:0] idle;
    logic lvl_d;
    logic tx_empty_d;
    logic rx_evt;
    logic tx_evt;
    logic [31:0] prdata;
  } state_t;
endpackage : uart_irq_pkg
`default_nettype wire

// File: verilog/uart_irq_fifo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_defines.svh"
// Function
// - three enables gate each interrupt type
// - latch select routes shared address to divisor
// - divisor high byte has dedicated address
// - priority: line status, receive, transmit
// - shared address: read id, write control
// - id bits 7-6 show queue mode
// - id bits 3-1 encode top interrupt
// - bit 0 low while enabled interrupt pending
// - line status from errors; overrun cleared by read
// - data ready: buffer full or trigger reached
// - data ready reasserted after four idle characters
// - timeout after four idle characters, cleared
// - transmit empty interrupt until character written
// - first reader of receive queue clears
// - other control bits ignored unless mode on
// - trigger code selects 1, 4, 8, 14
// - bit 2 flushes transmit queue
// - bit 1 flushes receive queue
// - mode bit off clears both queues
// - sixteen byte queues in queue mode
// - no dma events in plain mode
module uart_irq_fifo_ctrl import uart_irq_pkg::*; (
  input wire logic pclk, // 100 MHz bus clock
  input wire logic presetn, // async reset, active low
  input wire apb_req_t apb, // apb request group
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped offset
  output logic [31:0] prdata, // apb read data
  input wire logic bclk_tick, // 16x baud enable pulse
  input wire rx_char_t rx_in, // character from receive shifter
  input wire logic receiver_reset_n, // receiver reset, low holds reset
  input wire logic tx_take, // transmit shifter takes head byte
  input wire logic tx_shift_busy, // transmit shifter holds a byte
  output logic tx_valid, // transmit queue not empty
  output logic [7:0] tx_data, // head of transmit queue
  output logic irq, // interrupt request, active high
  output logic rx_dma_event, // receive dma event pulse
  output logic tx_dma_event, // transmit dma event pulse
  output logic dma_handshake_select, // dma mode select bit
  output logic [7:0] divisor_high_byte, // to baud generator
  output logic [7:0] line_format_register // to serial datapath
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `OFS_DATA) || (a == `OFS_IEN) || (a == `OFS_IID) ||
                (a == `OFS_LFR) || (a == `OFS_LSR) || (a == `OFS_DHB);
  endfunction : is_mapped

  function automatic logic [4:0] trig_bytes(input logic [1:0] code);
    case (code)
      2'h0: trig_bytes = `TRIG_L0;
      2'h1: trig_bytes = `TRIG_L1;
      2'h2: trig_bytes = `TRIG_L2;
      default: trig_bytes = `TRIG_L3;
    endcase
  endfunction : trig_bytes

  // four frames in baud ticks: start + data + parity, then stop
  function automatic logic [11:0] idle_limit(input logic [7:0] lf);
    logic [9:0] bits;
    logic [9:0] stop;
    bits = 10'h006 + {8'h00, lf[1:0]} + {9'h000, lf[3]};
    if (!lf[2]) begin
      stop = `STOP_ONE;
    end else if (lf[1:0] == 2'h0) begin
      stop = `STOP_HALF;
    end else begin
      stop = `STOP_TWO;
    end
    idle_limit = {2'h0, 10'(bits * `BCLK_PER_BIT) + stop} << `CHAR_TIMES_SHIFT;
  endfunction : idle_limit

  state_t st;
  state_t nx;
  logic access;
  logic latch;
  logic [4:0] cap;
  logic rx_pop;
  logic rx_push;
  logic tx_push;
  logic tx_pop;
  logic qc_wr;
  logic mode_change;
  logic rx_flush;
  logic tx_flush;
  logic ls_read;
  logic rx_lvl;
  logic ls_pend;
  logic tx_empty;
  logic expire;
  logic head_err;
  logic [2:0] new_err;
  logic ls_irq;
  logic rx_irq;
  logic tx_irq;
  logic [2:0] irq_code;
  logic [7:0] line_status_register;

  // ----------------------------------------
  // decode and status
  // ----------------------------------------
  always_comb begin
    access = apb.psel & apb.penable;
    latch = st.line_format_register[`LFR_LATCH];
    cap = st.queue_mode_on ? `Q_DEPTH : `Q_ONE;
    rx_pop = access & ~apb.pwrite & (apb.paddr == `OFS_DATA) & ~latch & (st.rx_cnt != 5'h00);
    tx_push = access & apb.pwrite & (apb.paddr == `OFS_DATA) & ~latch & (st.tx_cnt < cap);
    tx_pop = tx_take & (st.tx_cnt != 5'h00);
    rx_push = rx_in.valid & (st.rx_cnt < cap);
    qc_wr = access & apb.pwrite & (apb.paddr == `OFS_IID);
    mode_change = qc_wr & (apb.pwdata[`QC_EN] != st.queue_mode_on);
    rx_flush = mode_change | (qc_wr & st.queue_mode_on & apb.pwdata[`QC_RXFL]);
    tx_flush = mode_change | (qc_wr & st.queue_mode_on & apb.pwdata[`QC_TXFL]);
    ls_read = access & ~apb.pwrite & (apb.paddr == `OFS_LSR);
    head_err = |st.rx_mem[st.rx_rp][10:8];
    new_err = {rx_in.parity_err, rx_in.frame_err, rx_in.brk};
    rx_lvl = st.queue_mode_on ? (st.rx_cnt >= trig_bytes(st.rx_trigger_level)) : (st.rx_cnt != 5'h00);
    ls_pend = st.overrun | (st.rx_errs != 5'h00);
    tx_empty = (st.tx_cnt == 5'h00);
    expire = st.queue_mode_on & bclk_tick & (st.rx_cnt != 5'h00) & ~rx_pop & ~rx_push &
             receiver_reset_n & (st.idle >= idle_limit(st.line_format_register) - 12'h001);
    ls_irq = st.ien[`IEN_LS] & ls_pend;
    rx_irq = st.ien[`IEN_RX] & (rx_lvl | st.timeout);
    tx_irq = st.ien[`IEN_TX] & tx_empty;
    if (ls_irq) begin
      irq_code = `ID_LS;
    end else if (rx_irq) begin
      irq_code = rx_lvl ? `ID_RX : `ID_TO;
    end else if (tx_irq) begin
      irq_code = `ID_TX;
    end else begin
      irq_code = `ID_NONE;
    end
    line_status_register = {(st.rx_errs != 5'h00), tx_empty & ~tx_shift_busy, tx_empty,
           st.rx_mem[st.rx_rp][8], st.rx_mem[st.rx_rp][9], st.rx_mem[st.rx_rp][10],
           st.overrun, (st.rx_cnt != 5'h00)};
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    // read data captured in setup; head cannot move before access, but status and id flags can change in the access cycle
    if (apb.psel & ~apb.penable) begin
      case (apb.paddr)
        `OFS_DATA: nx.prdata = {24'h000000, (latch | (st.rx_cnt == 5'h00)) ? 8'h00 : st.rx_mem[st.rx_rp][7:0]};
        `OFS_IEN: nx.prdata = {24'h000000, latch ? st.divisor_high_byte : {5'h00, st.ien}};
        `OFS_IID: nx.prdata = {24'h000000, st.queue_mode_on ? `MODE_FIFO : `MODE_PLAIN,
                               2'h0, irq_code, ~(ls_irq | rx_irq | tx_irq)};
        `OFS_LFR: nx.prdata = {24'h000000, st.line_format_register};
        `OFS_LSR: nx.prdata = {24'h000000, line_status_register};
        `OFS_DHB: nx.prdata = {24'h000000, st.divisor_high_byte};
        default: nx.prdata = 32'h00000000;
      endcase
    end
    if (access & apb.pwrite) begin
      case (apb.paddr)
        `OFS_IEN: begin
          if (latch) begin
            nx.divisor_high_byte = apb.pwdata[7:0];
          end else begin
            nx.ien = apb.pwdata[2:0]; // bits 7-3 dropped
          end
        end
        `OFS_LFR: nx.line_format_register = apb.pwdata[7:0];
        `OFS_DHB: nx.divisor_high_byte = apb.pwdata[7:0];
        `OFS_IID: begin
          nx.queue_mode_on = apb.pwdata[`QC_EN];
          if (st.queue_mode_on) begin
            nx.rx_trigger_level = apb.pwdata[7:6];
            nx.dma_handshake_select = apb.pwdata[`QC_DMA];
          end
        end
        default: nx.prdata = st.prdata;
      endcase
    end
    // receive queue
    if (rx_flush) begin
      nx.rx_wp = 4'h0;
      nx.rx_rp = 4'h0;
      nx.rx_cnt = 5'h00;
      nx.rx_errs = 5'h00;
      nx.timeout = 1'b0;
      nx.idle = 12'h000;
    end else begin
      if (rx_push) begin
        nx.rx_mem[st.rx_wp] = {new_err, rx_in.data};
        nx.rx_wp = st.rx_wp + 4'h1;
      end
      if (rx_pop) begin
        nx.rx_rp = st.rx_rp + 4'h1;
      end
      nx.rx_cnt = st.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
      nx.rx_errs = st.rx_errs + {4'h0, rx_push & (|new_err)} - {4'h0, rx_pop & head_err};
      if (rx_pop | rx_push | ~receiver_reset_n | ~st.queue_mode_on | (st.rx_cnt == 5'h00)) begin
        nx.idle = 12'h000;
        nx.timeout = st.timeout & ~(rx_pop | rx_push | ~receiver_reset_n | ~st.queue_mode_on);
      end else if (expire) begin
        nx.idle = 12'h000;
        nx.timeout = 1'b1;
      end else if (bclk_tick) begin
        nx.idle = st.idle + 12'h001;
      end
    end
    // overrun: a new one wins over the clearing read
    if (rx_in.valid & ~rx_push & ~rx_flush) begin
      nx.overrun = 1'b1;
    end else if (ls_read) begin
      nx.overrun = 1'b0;
    end
    // transmit queue
    if (tx_flush) begin
      nx.tx_wp = 4'h0;
      nx.tx_rp = 4'h0;
      nx.tx_cnt = 5'h00;
    end else begin
      if (tx_push) begin
        nx.tx_mem[st.tx_wp] = apb.pwdata[7:0];
        nx.tx_wp = st.tx_wp + 4'h1;
      end
      if (tx_pop) begin
        nx.tx_rp = st.tx_rp + 4'h1;
      end
      nx.tx_cnt = st.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    end
    // dma events, queue mode only
    nx.lvl_d = rx_lvl;
    nx.tx_empty_d = tx_empty;
    nx.rx_evt = st.queue_mode_on & ((rx_lvl & ~st.lvl_d) | (expire & rx_lvl));
    nx.tx_evt = st.queue_mode_on & tx_empty & ~st.tx_empty_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ien <= `RST_IEN;
      st.divisor_high_byte <= `RST_BYTE;
      st.line_format_register <= `RST_BYTE;
      st.rx_trigger_level <= `RST_TRIG;
      st.lvl_d <= 1'b0;
      st.tx_empty_d <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = access & ~is_mapped(apb.paddr);
  assign prdata = st.prdata;
  assign tx_valid = ~tx_empty;
  assign tx_data = st.tx_mem[st.tx_rp];
  assign irq = ls_irq | rx_irq | tx_irq;
  assign rx_dma_event = st.rx_evt;
  assign tx_dma_event = st.tx_evt;
  assign dma_handshake_select = st.dma_handshake_select;
  assign divisor_high_byte = st.divisor_high_byte;
  assign line_format_register = st.line_format_register;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_irq_gated: assert property ((st.ien == 3'h0) |-> !irq)
    else $error("irq raised with all enables clear");
  chk_latch_route: assert property ((access && apb.pwrite && apb.paddr == `OFS_IEN && latch)
    |=> (st.divisor_high_byte == $past(apb.pwdata[7:0])) && $stable(st.ien))
    else $error("shared address write with latch set missed divisor");
  chk_dhb_direct: assert property ((access && apb.pwrite && apb.paddr == `OFS_DHB)
    |=> st.divisor_high_byte == $past(apb.pwdata[7:0]))
    else $error("dedicated divisor write lost");
  chk_ls_priority: assert property ((apb.psel && !apb.penable && apb.paddr == `OFS_IID && ls_irq)
    |=> prdata[3:0] == {`ID_LS, 1'b0})
    else $error("line status not reported first");
  chk_iir_mode: assert property ((apb.psel && !apb.penable && apb.paddr == `OFS_IID)
    |=> prdata[7:6] == ($past(st.queue_mode_on) ? `MODE_FIFO : `MODE_PLAIN))
    else $error("mode bits wrong in identification");
  chk_rx_flush: assert property ((qc_wr && st.queue_mode_on && apb.pwdata[`QC_RXFL])
    |=> st.rx_cnt == 5'h00 && !st.timeout)
    else $error("receive flush left data");
  chk_tx_flush: assert property ((qc_wr && st.queue_mode_on && apb.pwdata[`QC_TXFL])
    |=> tx_valid == 1'b0)
    else $error("transmit flush left data");
  chk_qc_ignored: assert property ((qc_wr && !st.queue_mode_on)
    |=> $stable(st.rx_trigger_level) && $stable(st.dma_handshake_select))
    else $error("control bits taken with queue mode off");
  chk_plain_dma: assert property ($past(!st.queue_mode_on) |-> !rx_dma_event && !tx_dma_event)
    else $error("dma event in plain mode");
  chk_timeout_clr: assert property ((rx_pop || rx_push) && !expire |=> !st.timeout)
    else $error("timeout survived queue access");

  chk_pend_flag: assert property ((apb.psel && !apb.penable && apb.paddr == `OFS_IID)
    |=> prdata[0] == !$past(irq))
    else $error("pending flag disagrees with irq");

  chk_qc_mode_write: assert property ((access && apb.pwrite && apb.paddr == `OFS_IID)
    |=> st.queue_mode_on == $past(apb.pwdata[`QC_EN]))
    else $error("control write at shared address lost");

  chk_mode_off: assert property ((qc_wr && !apb.pwdata[`QC_EN] && st.queue_mode_on)
    |=> !st.queue_mode_on && st.rx_cnt == 5'h00 && st.tx_cnt == 5'h00)
    else $error("leaving queue mode kept data");

  chk_tx_push: assert property ((tx_push && !tx_flush)
    |=> tx_valid)
    else $error("transmit empty after character written");

  chk_queue_cap: assert property ((st.rx_cnt <= cap) &&
    (st.tx_cnt <= cap))
    else $error("queue count above capacity");

  chk_timeout_set: assert property ((expire && !rx_flush)
    |=> st.timeout)
    else $error("timeout not raised at expiry");

  chk_rx_reassert: assert property ((expire && rx_lvl)
    |=> rx_dma_event)
    else $error("data ready not reasserted after idle");
endmodule : uart_irq_fifo_ctrl
`default_nettype wire

// File: verif/host_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// transmit shifter and dma event counter
// ----------------------------------------
module host_dma_model (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic rx_dma_event, // receive event pulse
  input wire logic tx_dma_event, // transmit event pulse
  input wire logic tx_valid, // transmit queue not empty
  input wire logic take_en, // low stalls the shifter
  output logic tx_take, // takes head byte
  output logic [15:0] rx_cnt, // receive events seen
  output logic [15:0] tx_cnt // transmit events seen
);
  // one take per two cycles so a stalled shifter shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_take <= 1'b0;
      rx_cnt <= 16'h0000;
      tx_cnt <= 16'h0000;
    end else begin
      tx_take <= take_en & tx_valid & ~tx_take;
      rx_cnt <= rx_cnt + {15'h0000, rx_dma_event};
      tx_cnt <= tx_cnt + {15'h0000, tx_dma_event};
    end
  end
endmodule : host_dma_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", n, x, g); end end
module tb_top import uart_irq_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t apb = '0;
  rx_char_t rx_in = '0;
  logic bclk_tick = 1'b0;
  logic receiver_reset_n = 1'b1;
  logic take_en = 1'b0;
  logic pready, pslverr, tx_take, tx_valid, irq, rx_ev, tx_ev, dma_sel, e;
  logic [31:0] prdata, q;
  logic [7:0] tx_data, dhb, lfr;
  logic [15:0] rx_cnt, tx_cnt;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int lvl[4] = '{1, 4, 8, 14};
  uart_irq_fifo_ctrl uart_irq_fifo_ctrl_i (.pclk(pclk), .presetn(presetn), .apb(apb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .bclk_tick(bclk_tick), .rx_in(rx_in), .receiver_reset_n(receiver_reset_n),
    .tx_take(tx_take), .tx_shift_busy(1'b0), .tx_valid(tx_valid), .tx_data(tx_data), .irq(irq),
    .rx_dma_event(rx_ev), .tx_dma_event(tx_ev), .dma_handshake_select(dma_sel), .divisor_high_byte(dhb),
    .line_format_register(lfr));
  host_dma_model host_dma_model_i (.pclk(pclk), .presetn(presetn), .rx_dma_event(rx_ev), .tx_dma_event(tx_ev),
    .tx_valid(tx_valid), .take_en(take_en), .tx_take(tx_take), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) bclk_tick <= ~bclk_tick;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  // only the bench timeout ends a wait for ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) apb <= '{paddr:a, psel:1'b1, penable:1'b0, pwrite:w, pwdata:d};
    @(posedge pclk) apb.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb <= '0;
    #1;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string n);
    xfer(1'b0, a, 32'h00000000);
    `CHK(n, {24'h000000, x}, q)
  endtask : rd
  task automatic push(input logic [7:0] d, input logic pe);
    @(posedge pclk) rx_in <= '{valid:1'b1, data:d, parity_err:pe, frame_err:1'b0, brk:1'b0};
    @(posedge pclk) rx_in <= '0;
    #1;
  endtask : push
  // polling only reads identification, so the receive queue stays untouched
  task automatic wait_iid(input logic [7:0] x);
    int n;
    n = 0;
    do begin
      xfer(1'b0, 8'h08, 32'h00000000);
      n++;
    end while (q[7:0] !== x && n < 600);
    `CHK("iid wait", {24'h000000, x}, q)
  endtask : wait_iid
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 8'h01, "iid reset");
    rd(8'h04, 8'h00, "ien reset");
    wr(8'h04, 8'h02);
    rd(8'h08, 8'h02, "tx empty");
    `CHK("irq", 1'b1, irq)
    wr(8'h00, 8'h5a);
    `CHK("tx data", 8'h5a, tx_data)
    rd(8'h08, 8'h01, "tx loaded");
    @(posedge pclk) take_en <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(8'h08, 8'h02, "tx taken");
    wr(8'h0c, 8'h80);
    wr(8'h04, 8'h55);
    `CHK("divisor shared", 8'h55, dhb)
    rd(8'h08, 8'h02, "iid latch");
    wr(8'h0c, 8'h00);
    rd(8'h04, 8'h02, "ien back");
    wr(8'h24, 8'haa);
    `CHK("divisor own", 8'haa, dhb)
    rd(8'h04, 8'h02, "ien kept");
    wr(8'h04, 8'h07);
    push(8'h11, 1'b0);
    rd(8'h08, 8'h04, "rx over tx");
    rd(8'h00, 8'h11, "rx data");
    rd(8'h08, 8'h02, "rx read");
    push(8'h33, 1'b1);
    rd(8'h08, 8'h06, "parity");
    rd(8'h00, 8'h33, "bad data");
    rd(8'h08, 8'h02, "parity gone");
    push(8'h44, 1'b0);
    push(8'h55, 1'b0);
    rd(8'h08, 8'h06, "overrun");
    rd(8'h14, 8'h63, "line status");
    rd(8'h08, 8'h04, "overrun read");
    rd(8'h00, 8'h44, "kept char");
    `CHK("plain events", 32'h0, {rx_cnt, tx_cnt})
    wr(8'h08, 8'h08);
    rd(8'h08, 8'h02, "still plain");
    wr(8'h08, 8'h09);
    `CHK("dma ignored", 1'b0, dma_sel)
    rd(8'h08, 8'hc2, "queue mode");
    wr(8'h04, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {i[1:0], 6'h0b});
      repeat (lvl[i] - 1) push(8'h10, 1'b0);
      rd(8'h08, 8'hc1, "below level");
      push(8'h10, 1'b0);
      rd(8'h08, 8'hc4, "level");
    end
    `CHK("dma select", 1'b1, dma_sel)
    `CHK("level events", 16'h0004, rx_cnt)
    // one idle expiry of the default frame fits in this wait, a second does not
    repeat (1000) @(posedge pclk);
    rd(8'h08, 8'hc4, "level held");
    `CHK("reassert event", 16'h0005, rx_cnt)
    push(8'h10, 1'b0);
    push(8'h10, 1'b0);
    rd(8'h08, 8'hc4, "sixteen");
    push(8'h10, 1'b0);
    rd(8'h08, 8'hc6, "queue overrun");
    xfer(1'b0, 8'h14, 32'h00000000);
    wr(8'h08, 8'h4b);
    rd(8'h08, 8'hc1, "rx flush");
    push(8'h66, 1'b0);
    wait_iid(8'hcc);
    push(8'h77, 1'b0);
    rd(8'h08, 8'hc1, "arrival");
    wait_iid(8'hcc);
    rd(8'h00, 8'h66, "pop");
    rd(8'h08, 8'hc1, "pop clears");
    wait_iid(8'hcc);
    @(posedge pclk) receiver_reset_n <= 1'b0;
    rd(8'h08, 8'hc1, "rx reset");
    @(posedge pclk) receiver_reset_n <= 1'b1;
    // longest frame: expiry near 1536 cycles, the default would have fired long before
    wr(8'h0c, 8'h0f);
    `CHK("format out", 8'h0f, lfr)
    push(8'h88, 1'b0);
    repeat (1400) @(posedge pclk);
    rd(8'h08, 8'hc1, "long frame");
    wait_iid(8'hcc);
    @(posedge pclk) take_en <= 1'b0;
    wr(8'h00, 8'h01);
    wr(8'h00, 8'h02);
    `CHK("tx filled", 1'b1, tx_valid)
    wr(8'h08, 8'h4d);
    `CHK("tx flush", 1'b0, tx_valid)
    wr(8'h00, 8'h03);
    wr(8'h08, 8'h00);
    `CHK("mode off", 1'b0, tx_valid)
    rd(8'h08, 8'h01, "plain again");
    `CHK("queue events", 32'h00050001, {rx_cnt, tx_cnt})
    xfer(1'b0, 8'h10, 32'h00000000);
    `CHK("unmapped", 1'b1, e)
    results();
  end
endmodule : tb_top
`default_nettype wire
